// ---- design/csrm_pkg.sv ----
package csrm_pkg;

	// Register byte offsets; the printed offsets are all multiples of four only partly, so
	// they are kept as indices and the byte address is four times the index.
	localparam logic [11:0] IDX_PRESENCE = 12'h22c;
	localparam logic [11:0] IDX_LOOPSTATE = 12'h22d;
	localparam logic [11:0] IDX_MONSEL = 12'h230;
	localparam logic [11:0] IDX_IRQSTAT = 12'h240;
	localparam logic [11:0] IDX_IRQMASK = 12'h241;
	localparam logic [13:0] ADDR_PRESENCE = {IDX_PRESENCE, 2'h0};
	localparam logic [13:0] ADDR_LOOPSTATE = {IDX_LOOPSTATE, 2'h0};
	localparam logic [13:0] ADDR_MONSEL = {IDX_MONSEL, 2'h0};
	localparam logic [13:0] ADDR_IRQSTAT = {IDX_IRQSTAT, 2'h0};
	localparam logic [13:0] ADDR_IRQMASK = {IDX_IRQMASK, 2'h0};

	// Field positions of the loop state register.
	localparam int POS_HOLDOVER = 3;
	localparam int POS_AUTOSEL = 2;
	localparam int POS_CALIB = 0;
	localparam int MONSEL_W = 6;

	localparam logic [5:0] MONSEL_RESET = 6'h00;
	localparam logic [7:0] IRQMASK_RESET = 8'h00;

	// Monitor selector codes.
	localparam logic [5:0] SEL_BOTHLOCK = 6'h01;
	localparam logic [5:0] SEL_LOCKIN = 6'h02;
	localparam logic [5:0] SEL_LOCKOUT = 6'h03;
	localparam logic [5:0] SEL_REFSMISS = 6'h04;
	localparam logic [5:0] SEL_MISSLOCK = 6'h05;
	localparam logic [5:0] SEL_REFBSEL = 6'h06;
	localparam logic [5:0] SEL_OKREFA = 6'h07;
	localparam logic [5:0] SEL_OKREFB = 6'h08;
	localparam logic [5:0] SEL_OKTEST = 6'h09;
	localparam logic [5:0] SEL_OKOSC = 6'h0a;
	localparam logic [5:0] SEL_OKINFB = 6'h0b;
	localparam logic [5:0] SEL_OKOUTREF = 6'h0c;
	localparam logic [5:0] SEL_BOTHREFOK = 6'h0e;
	localparam logic [5:0] SEL_ALLOK = 6'h0f;
	localparam logic [5:0] SEL_DIVFB = 6'h10;
	localparam logic [5:0] SEL_DIVDN = 6'h11;
	localparam logic [5:0] SEL_DIVREF = 6'h12;
	localparam logic [5:0] SEL_DIVUP = 6'h13;

	// Live conditions of the clock generator.
	typedef struct packed {
		logic outLoopRefOk;
		logic outLoopFbOk;
		logic oscOk;
		logic testRefOk;
		logic refBOk;
		logic refAOk;
		logic outLoopLock;
		logic inLoopLock;
		logic holdover;
		logic autoSelRefB;
		logic calibBusy;
	} csrm_status_t;

	// Raw loop clocks to be halved for the monitor.
	typedef struct packed {
		logic fb;
		logic pfdDown;
		logic refClk;
		logic pfdUp;
	} csrm_loopclk_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [15:0] paddr;
		logic [31:0] pwdata;
	} csrm_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} csrm_apb_rsp_t;

	// Used only by the top, to build the presence byte.
	function automatic logic [7:0] csrm_presence_byte(input csrm_status_t s);
		return {s.outLoopRefOk, s.outLoopFbOk, s.oscOk, s.testRefOk,
			s.refBOk, s.refAOk, s.outLoopLock, s.inLoopLock};
	endfunction

endpackage

// ---- design/csrm_halver.sv ----
`timescale 1ns/1ns
`default_nettype none
// Halves each loop clock: a flop toggles on every rising edge seen at mclk.
module csrm_halver (
	input  wire logic                   mclk,
	input  wire logic                   rst,
	input  wire logic                   ce,
	input  wire csrm_pkg::csrm_loopclk_t rawClk,
	output var  csrm_pkg::csrm_loopclk_t halfClk
);
	typedef struct packed {
		csrm_pkg::csrm_loopclk_t prev;
		csrm_pkg::csrm_loopclk_t half;
	} csrm_halver_t;

	csrm_halver_t state_q;
	csrm_halver_t state_d;

	always_comb begin
		state_d = state_q;
		state_d.prev = rawClk;
		state_d.half = state_q.half ^ (rawClk & ~state_q.prev);
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q <= '0;
		end else if (ce) begin
			state_q <= state_d;
		end
	end

	assign halfClk = state_q.half;
endmodule // csrm_halver
`default_nettype wire

// ---- design/csrm_monmux.sv ----
`timescale 1ns/1ns
`default_nettype none
// Registered status monitor selector.
module csrm_monmux (
	input  wire logic                   mclk,
	input  wire logic                   rst,
	input  wire logic                   ce,
	input  wire logic [5:0]             sel,
	input  wire csrm_pkg::csrm_status_t  st,
	input  wire csrm_pkg::csrm_loopclk_t half,
	output var  logic                   monOut
);
	typedef struct packed {
		logic mon;
	} csrm_monmux_t;

	csrm_monmux_t state_q;
	csrm_monmux_t state_d;
	logic         bothMiss;

	always_comb begin
		bothMiss = ~st.refAOk & ~st.refBOk;
		state_d = state_q;
		unique case (sel)
			csrm_pkg::SEL_BOTHLOCK:  state_d.mon = st.inLoopLock & st.outLoopLock;
			csrm_pkg::SEL_LOCKIN:    state_d.mon = st.inLoopLock;
			csrm_pkg::SEL_LOCKOUT:   state_d.mon = st.outLoopLock;
			csrm_pkg::SEL_REFSMISS:  state_d.mon = bothMiss;
			csrm_pkg::SEL_MISSLOCK:  state_d.mon = bothMiss & st.outLoopLock;
			csrm_pkg::SEL_REFBSEL:   state_d.mon = st.autoSelRefB;
			csrm_pkg::SEL_OKREFA:    state_d.mon = st.refAOk;
			csrm_pkg::SEL_OKREFB:    state_d.mon = st.refBOk;
			csrm_pkg::SEL_OKTEST:    state_d.mon = st.testRefOk;
			csrm_pkg::SEL_OKOSC:     state_d.mon = st.oscOk;
			csrm_pkg::SEL_OKINFB:    state_d.mon = st.outLoopFbOk;
			csrm_pkg::SEL_OKOUTREF:  state_d.mon = st.outLoopRefOk;
			csrm_pkg::SEL_BOTHREFOK: state_d.mon = st.refAOk & st.refBOk;
			csrm_pkg::SEL_ALLOK:     state_d.mon = st.refAOk & st.refBOk & st.oscOk
				& st.outLoopFbOk & st.outLoopRefOk;
			csrm_pkg::SEL_DIVFB:     state_d.mon = half.fb;
			csrm_pkg::SEL_DIVDN:     state_d.mon = half.pfdDown;
			csrm_pkg::SEL_DIVREF:    state_d.mon = half.refClk;
			csrm_pkg::SEL_DIVUP:     state_d.mon = half.pfdUp;
			default:                 state_d.mon = 1'b0;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q <= '0;
		end else if (ce) begin
			state_q <= state_d;
		end
	end

	assign monOut = state_q.mon;
endmodule // csrm_monmux
`default_nettype wire

// ---- design/csrm_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module csrm_top (
	input  wire logic                    mclk,
	input  wire logic                    rst,
	input  wire logic                    ce,
	input  wire csrm_pkg::csrm_apb_req_t  apbReq,
	output var  csrm_pkg::csrm_apb_rsp_t  apbRsp,
	input  wire csrm_pkg::csrm_status_t   status,
	input  wire csrm_pkg::csrm_loopclk_t  loopClk,
	output var  logic                    statusMon,
	output var  logic                    irq
);
	typedef struct packed {
		csrm_pkg::csrm_apb_rsp_t rsp;
		logic [5:0]             monSel;
		logic [7:0]             prevPresence;
		logic [7:0]             irqStat;
		logic [7:0]             irqMask;
		logic                   irq;
	} csrm_top_t;

	csrm_top_t               state_q;
	csrm_top_t               state_d;
	csrm_pkg::csrm_loopclk_t halfClk;
	logic                    monOut;
	logic [7:0]              presence;
	logic [7:0]              loopState;
	logic [7:0]              events;
	logic                    access;
	logic                    wrEn;

	csrm_halver u_halver (
		.mclk    (mclk),
		.rst     (rst),
		.ce      (ce),
		.rawClk  (loopClk),
		.halfClk (halfClk)
	);

	csrm_monmux u_monmux (
		.mclk   (mclk),
		.rst    (rst),
		.ce     (ce),
		.sel    (state_q.monSel),
		.st     (status),
		.half   (halfClk),
		.monOut (monOut)
	);

	always_comb begin
		presence = csrm_pkg::csrm_presence_byte(status);
		loopState = 8'h00;
		loopState[csrm_pkg::POS_HOLDOVER] = status.holdover;
		loopState[csrm_pkg::POS_AUTOSEL] = status.autoSelRefB;
		loopState[csrm_pkg::POS_CALIB] = status.calibBusy;
		// Any change of a presence or lock bit is an interrupt event.
		events = presence ^ state_q.prevPresence;
		access = apbReq.psel & apbReq.penable & ~state_q.rsp.pready;
		wrEn = access & apbReq.pwrite;

		state_d = state_q;
		state_d.prevPresence = presence;
		state_d.rsp.pready = access;
		state_d.rsp.pslverr = 1'b0;
		state_d.rsp.prdata = 32'h0000_0000;
		if (access) begin
			unique case (apbReq.paddr[13:0])
				csrm_pkg::ADDR_PRESENCE:  state_d.rsp.prdata = {24'h000000, presence};
				csrm_pkg::ADDR_LOOPSTATE: state_d.rsp.prdata = {24'h000000, loopState};
				csrm_pkg::ADDR_MONSEL:    state_d.rsp.prdata = {26'h0000000, state_q.monSel};
				csrm_pkg::ADDR_IRQSTAT:   state_d.rsp.prdata = {24'h000000, state_q.irqStat};
				csrm_pkg::ADDR_IRQMASK:   state_d.rsp.prdata = {24'h000000, state_q.irqMask};
				default:                  state_d.rsp.pslverr = 1'b1;
			endcase
			if (apbReq.paddr[15:14] != 2'h0) begin
				state_d.rsp.pslverr = 1'b1;
			end
		end
		if (wrEn && apbReq.paddr[15:0] == {2'h0, csrm_pkg::ADDR_MONSEL}) begin
			state_d.monSel = apbReq.pwdata[5:0];
		end
		if (wrEn && apbReq.paddr[15:0] == {2'h0, csrm_pkg::ADDR_IRQMASK}) begin
			state_d.irqMask = apbReq.pwdata[7:0];
		end
		// Write-one-to-clear; a new event in the same cycle wins.
		state_d.irqStat = state_q.irqStat;
		if (wrEn && apbReq.paddr[15:0] == {2'h0, csrm_pkg::ADDR_IRQSTAT}) begin
			state_d.irqStat = state_q.irqStat & ~apbReq.pwdata[7:0];
		end
		state_d.irqStat = state_d.irqStat | events;
		state_d.irq = |(state_d.irqStat & state_d.irqMask);
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q <= '0;
			state_q.monSel <= csrm_pkg::MONSEL_RESET;
			state_q.irqMask <= csrm_pkg::IRQMASK_RESET;
		end else if (ce) begin
			state_q <= state_d;
		end
	end

	// The previous-presence flop starts at zero, so bits already present at reset
	// release raise one event each in the first enabled cycle.
	assign apbRsp = state_q.rsp;
	assign statusMon = monOut;
	assign irq = state_q.irq;
endmodule // csrm_top
`default_nettype wire

// ---- testbench/csrm_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
module csrm_monitor (
	input wire logic                    mclk,
	input wire logic                    rst,
	input wire logic                    ce,
	input wire csrm_pkg::csrm_apb_req_t  apbReq,
	input wire csrm_pkg::csrm_apb_rsp_t  apbRsp,
	input wire csrm_pkg::csrm_status_t   status,
	input wire csrm_pkg::csrm_loopclk_t  loopClk,
	input wire logic                    statusMon,
	input wire logic                    irq
);
	localparam logic [15:0] PRES = 16'(csrm_pkg::ADDR_PRESENCE);
	localparam logic [15:0] LOOP = 16'(csrm_pkg::ADDR_LOOPSTATE);
	localparam logic [15:0] SEL = 16'(csrm_pkg::ADDR_MONSEL);
	logic [5:0] selQ;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// Shadow of the selector, one cycle behind the register it mirrors.
	always_ff @(posedge mclk) begin
		if (rst)
			selQ <= 6'h00;
		else if (ce && apbRsp.pready && apbReq.pwrite && apbReq.paddr == SEL)
			selQ <= apbReq.pwdata[5:0];
	end
	sequence rdPres;
		apbRsp.pready && !apbReq.pwrite && apbReq.paddr == PRES;
	endsequence
	sequence rdLoop;
		apbRsp.pready && !apbReq.pwrite && apbReq.paddr == LOOP;
	endsequence
	chk_out_loop_clk:
	assert property (rdPres |-> apbRsp.prdata[7:6] == $past({status.outLoopRefOk,
		status.outLoopFbOk})) else $error("loop clock bits wrong");
	chk_input_clk_bits:
	assert property (rdPres |-> apbRsp.prdata[5:2] == $past({status.oscOk, status.testRefOk,
		status.refBOk, status.refAOk})) else $error("input clock bits wrong");
	chk_lock_bits:
	assert property (rdPres |-> apbRsp.prdata[1:0] == $past({status.outLoopLock,
		status.inLoopLock})) else $error("lock bits wrong");
	chk_holdover_bit:
	assert property (rdLoop |-> apbRsp.prdata[3] == $past(status.holdover)) else $error("holdover");
	chk_autosel_bit:
	assert property (rdLoop |-> apbRsp.prdata[2] == $past(status.autoSelRefB)) else $error("autosel");
	chk_calib_bit:
	assert property (rdLoop |-> apbRsp.prdata[31:4] == 28'h0 && !apbRsp.prdata[1]
		&& apbRsp.prdata[0] == $past(status.calibBusy)) else $error("calib or reserved");
	chk_ground_codes:
	assert property (selQ == 6'h00 || selQ inside {[6'h14:6'h17]} |-> !statusMon)
		else $error("ground code drives monitor");
	chk_both_lock:
	assert property (selQ == csrm_pkg::SEL_BOTHLOCK |-> statusMon ==
		$past(status.inLoopLock && status.outLoopLock)) else $error("combined lock");
	chk_ref_a_ok:
	assert property (selQ == csrm_pkg::SEL_OKREFA |-> statusMon == $past(status.refAOk))
		else $error("reference A present");
endmodule // csrm_monitor
bind csrm_top csrm_monitor csrm_monitor_i (.mclk(mclk), .rst(rst), .ce(ce), .apbReq(apbReq),
	.apbRsp(apbRsp), .status(status), .loopClk(loopClk), .statusMon(statusMon), .irq(irq));
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
module testbench;
	localparam logic [15:0] A_PRES = 16'(csrm_pkg::ADDR_PRESENCE);
	localparam logic [15:0] A_LOOP = 16'(csrm_pkg::ADDR_LOOPSTATE);
	localparam logic [15:0] A_SEL = 16'(csrm_pkg::ADDR_MONSEL);
	localparam logic [15:0] A_STAT = 16'(csrm_pkg::ADDR_IRQSTAT);
	localparam logic [15:0] A_MASK = 16'(csrm_pkg::ADDR_IRQMASK);
	logic                    mclk = 1'b0;
	logic                    rst = 1'b1;
	csrm_pkg::csrm_apb_req_t  req = '0;
	csrm_pkg::csrm_apb_rsp_t  rsp;
	csrm_pkg::csrm_status_t   st = '0;
	csrm_pkg::csrm_loopclk_t  lc = '0;
	logic                    mon;
	logic                    irq;
	logic [31:0]             rd;
	logic                    err;
	int                      num_errors = 0;
	int                      compares = 0;
	always #4 mclk = ~mclk;
	csrm_top csrm_top_i (.mclk(mclk), .rst(rst), .ce(1'b1), .apbReq(req), .apbRsp(rsp),
		.status(st), .loopClk(lc), .statusMon(mon), .irq(irq));
	task automatic summarize;
		if (num_errors == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// Read data is taken at the rising edge where pready is seen high; only the watchdog ends a wait.
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge mclk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge mclk);
		req.penable <= 1'b1;
		do begin
			@(posedge mclk);
		end while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	function automatic logic expMon(input logic [5:0] c, input csrm_pkg::csrm_status_t s);
		case (c)
			6'h01: return s.inLoopLock & s.outLoopLock;
			6'h02: return s.inLoopLock;
			6'h03: return s.outLoopLock;
			6'h04: return !s.refAOk & !s.refBOk;
			6'h05: return !s.refAOk & !s.refBOk & s.outLoopLock;
			6'h06: return s.autoSelRefB;
			6'h07: return s.refAOk;
			6'h08: return s.refBOk;
			6'h09: return s.testRefOk;
			6'h0a: return s.oscOk;
			6'h0b: return s.outLoopFbOk;
			6'h0c: return s.outLoopRefOk;
			6'h0e: return s.refAOk & s.refBOk;
			6'h0f: return s.refAOk & s.refBOk & s.oscOk & s.outLoopFbOk & s.outLoopRefOk;
			default: return 1'b0;
		endcase
	endfunction
	task automatic t_readback;
		for (int i = 0; i < 11; i++) begin
			@(posedge mclk);
			st <= csrm_pkg::csrm_status_t'(11'h1 << i);
			apb(1'b0, A_PRES, 32'h0);
			chk("presence", rd, {24'h0, st[10:3]});
			apb(1'b0, A_LOOP, 32'h0);
			chk("loopstate", rd, {28'h0, st[2:1], 1'b0, st[0]});
		end
		apb(1'b1, A_PRES, 32'hffffffff);
		chk("ro write err", 32'(err), 32'h0);
		apb(1'b0, A_PRES, 32'h0);
		chk("ro unchanged", rd, 32'h80);
		apb(1'b0, 16'h0ffc, 32'h0);
		chk("unmapped err", 32'(err), 32'h1);
	endtask
	task automatic t_monitor;
		logic [10:0] pats [5] = '{11'h7ff, 11'h000, 11'h2a5, 11'h55a, 11'h010};
		for (int p = 0; p < 5; p++)
			for (int c = 0; c < 24; c++)
				if (c < 16 || c > 19) begin
					@(posedge mclk);
					st <= csrm_pkg::csrm_status_t'(pats[p]);
					apb(1'b1, A_SEL, 32'(c));
					repeat (2) @(posedge mclk);
					@(negedge mclk);
					chk("monitor", 32'(mon), 32'(expMon(6'(c), pats[p])));
				end
		apb(1'b0, A_SEL, 32'h0);
		chk("selector", rd, 32'h17);
	endtask
	task automatic t_halver;
		int n;
		logic last;
		last = 1'b0;
		for (int c = 16; c < 20; c++) begin
			apb(1'b1, A_SEL, 32'(c));
			n = 0;
			for (int k = 0; k < 48; k++) begin
				@(posedge mclk);
				lc <= csrm_pkg::csrm_loopclk_t'(4'(k[1]) << (19 - c));
				@(negedge mclk);
				if (k > 15 && mon !== last)
					n++;
				last = mon;
			end
			chk("halved toggles", 32'(n), 32'd8);
		end
	endtask
	task automatic t_irq;
		@(posedge mclk);
		st <= '0;
		apb(1'b1, A_MASK, 32'h0);
		apb(1'b1, A_STAT, 32'hff);
		@(posedge mclk);
		st.refBOk <= 1'b1;
		repeat (3) @(posedge mclk);
		apb(1'b0, A_STAT, 32'h0);
		chk("irq status", rd, 32'h08);
		chk("irq masked", 32'(irq), 32'h0);
		apb(1'b1, A_MASK, 32'h08);
		@(negedge mclk);
		chk("irq raised", 32'(irq), 32'h1);
		apb(1'b1, A_STAT, 32'h08);
		@(negedge mclk);
		chk("irq cleared", 32'(irq), 32'h0);
	endtask
	initial begin
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		chk("reset monitor", 32'(mon), 32'h0);
		chk("reset irq", 32'(irq), 32'h0);
		t_readback;
		t_monitor;
		t_halver;
		t_irq;
		summarize;
	end
	initial begin
		#400000;
		num_errors++;
		summarize;
	end
endmodule // testbench
`default_nettype wire
